//--- tb/rfcfg_radio_fsm_config_monitor.sv
// checker for the radio fsm config register, watching the top ports only
// assumes: one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module rfcfg_radio_fsm_config_monitor
(
   // clock, reset and register port
   input wire logic                      clock,
   input wire logic                      resetn,
   input wire logic [5:0]                reg_addr,
   input wire logic                      reg_wr,
   input wire logic [7:0]                reg_wdata,
   input wire logic [7:0]                reg_rdata,
   // radio side
   input wire rfcfg_pkg::rfcfg_radio_state_t radio_state,
   input wire logic                      calibrate_strobe,
   input wire logic                      cal_start,
   input wire logic                      xosc_stable,
   input wire logic                      chip_ready_n,
   input wire logic                      xosc_enable,
   input wire rfcfg_pkg::rfcfg_pin_cmd_t pin_cmd,
   input wire rfcfg_pkg::rfcfg_pin_cmd_t pin_cmd_out,
   input wire rfcfg_pkg::rfcfg_config_t  config_out
);
   import rfcfg_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   // =========================================
   // named steps of calibration and power-on
   sequence s_leave_idle;
      $past(radio_state) == RFCFG_ST_IDLE && radio_state inside {RFCFG_ST_RX, RFCFG_ST_TX,
         RFCFG_ST_TX_SYNTH_ON};
   endsequence
   sequence s_back_idle;
      $past(radio_state) inside {RFCFG_ST_RX, RFCFG_ST_TX} && radio_state == RFCFG_ST_IDLE;
   endsequence
   sequence s_xosc_up_t0;
      $rose(xosc_stable) && config_out.power_on_ready_timeout == 2'h0;
   endsequence
   // one expiration is 64 crystal periods: still high at the 64th edge, low at the next
   sequence s_ready_after_one;
      ##63 chip_ready_n ##1 !chip_ready_n;
   endsequence
   AST_NEVER: assert property (config_out.auto_calibration_policy == RFCFG_CAL_NEVER &&
      !calibrate_strobe |=> !cal_start) else $error("calibration without cause");
   AST_STROBE: assert property (calibrate_strobe |=> cal_start)
      else $error("manual strobe not honoured");
   AST_FROM_IDLE: assert property (
      config_out.auto_calibration_policy == RFCFG_CAL_FROM_IDLE ##0 s_leave_idle |=> cal_start)
      else $error("no calibration leaving idle");
   AST_TO_IDLE: assert property (config_out.auto_calibration_policy == RFCFG_CAL_TO_IDLE
      ##0 s_back_idle |=> cal_start) else $error("no calibration returning to idle");
   AST_READY: assert property (s_xosc_up_t0 |-> s_ready_after_one)
      else $error("ready not asserted after one expiration");
   AST_NOT_READY: assert property (!xosc_stable |=> chip_ready_n)
      else $error("ready without stable crystal");
   AST_WRITE: assert property (reg_wr && reg_addr == 6'h18 |=> config_out == $past(reg_wdata[5:0]))
      else $error("register write lost");
   AST_READ: assert property (reg_addr == 6'h18 && !reg_wr |=> reg_rdata == {2'h0, config_out})
      else $error("register readback wrong");
   AST_UNMAPPED: assert property (reg_addr != 6'h18 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_PIN: assert property (1'b1 |=> pin_cmd_out ==
      ($past(config_out.pin_ctrl_en) ? $past(pin_cmd) : 3'h0)) else $error("pin gate wrong");
   AST_XOSC: assert property (1'b1 |=> xosc_enable ==
      ($past(radio_state) != RFCFG_ST_SLEEP || $past(config_out.xosc_force_on)))
      else $error("crystal enable wrong");
endmodule : rfcfg_radio_fsm_config_monitor
bind rfcfg_radio_fsm_config rfcfg_radio_fsm_config_monitor mon_u (.clock(clock), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .radio_state(radio_state), .calibrate_strobe(calibrate_strobe), .cal_start(cal_start),
   .xosc_stable(xosc_stable), .chip_ready_n(chip_ready_n), .xosc_enable(xosc_enable),
   .pin_cmd(pin_cmd), .pin_cmd_out(pin_cmd_out), .config_out(config_out));
`default_nettype wire

//--- tb/tb_rfcfg_radio_fsm_config.sv
// self-checking bench for the radio fsm config register
// assumes: bench drives all ports at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_rfcfg_radio_fsm_config;
   import rfcfg_pkg::*;
   logic               clock = 0, resetn = 0, reg_wr = 0, calibrate_strobe = 0, xosc_stable = 0;
   logic [5:0]         reg_addr = 6'h00;
   logic [7:0]         reg_wdata = 8'h00, reg_rdata, v;
   rfcfg_radio_state_t radio_state = RFCFG_ST_IDLE;
   rfcfg_pin_cmd_t     pin_cmd = 3'h0, pin_cmd_out;
   rfcfg_config_t      config_out;
   logic               cal_start, chip_ready_n, xosc_enable;
   int                 error_cnt = 0, compares = 0;
   logic               expq[$];
   logic               note;
   // =========================================
   // clock and design
   always #12.5 clock = ~clock;
   rfcfg_radio_fsm_config dut_u (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .radio_state(radio_state),
      .calibrate_strobe(calibrate_strobe), .cal_start(cal_start), .xosc_stable(xosc_stable),
      .chip_ready_n(chip_ready_n), .xosc_enable(xosc_enable), .pin_cmd(pin_cmd),
      .pin_cmd_out(pin_cmd_out), .config_out(config_out));
   // =========================================
   // helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         error_cnt++;
      end
   endtask : check
   task automatic tally_and_finish();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   task automatic do_reset();
      resetn = 0;
      repeat (12) @(negedge clock);
      resetn = 1;
   endtask : do_reset
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_addr = a; reg_wdata = d; reg_wr = 1;
      @(negedge clock);
      reg_wr = 0;
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      @(negedge clock);
      reg_addr = a;
      @(negedge clock);
      check(reg_rdata, exp);
   endtask : rd
   task automatic step(input rfcfg_radio_state_t s, input logic e);
      @(negedge clock);
      radio_state = s;
      if (e) expq.push_back(1'b1);
      repeat (3) @(negedge clock);
   endtask : step
   // power-on: raise the crystal, expect ready low after expire * 64 crystal periods
   task automatic power_on(input logic [1:0] sel, input int expire);
      wr(RFCFG_ADDR_CONFIG_ZERO, 8'(sel) << RFCFG_TIMEOUT_LSB);
      xosc_stable = 1;
      repeat (expire * (1 << RFCFG_RIPPLE_W) - 1) @(negedge clock);
      check(8'(chip_ready_n), 8'h01);
      @(negedge clock);
      check(8'(chip_ready_n), 8'h00);
      xosc_stable = 0;
      repeat (2) @(negedge clock);
      check(8'(chip_ready_n), 8'h01);
   endtask : power_on
   // watcher: each calibration pulse takes the oldest note off the queue, sampled mid-cycle
   always @(negedge clock)
      if (resetn === 1'b1 && cal_start !== 1'b0)
      begin
         note = (expq.size() != 0) ? expq.pop_front() : 1'b0;
         check(8'(note), 8'h01);
      end
   // watchdog: the tests take about 22000 cycles, the longest timeout alone 16384
   initial
   begin
      #(25 * 40000);
      error_cnt++;
      tally_and_finish();
   end
   // =========================================
   // test sequence
   initial
   begin
      void'($urandom(32135));
      do_reset();
      check(8'(config_out), 8'h04);
      rd(6'h18, 8'h04);
      check({chip_ready_n, xosc_enable}, 8'h03);
      repeat (4)
      begin
         v = 8'($urandom);
         wr(6'h18, v);
         wr(6'h21, ~v);
         rd(6'h18, {2'h0, v[5:0]});
         rd(6'h21, 8'h00);
      end
      $display("test registers done");
      wr(6'h18, 8'h02);
      pin_cmd = 3'($urandom % 7 + 1);
      repeat (2) @(negedge clock);
      check(8'(pin_cmd_out), 8'(pin_cmd));
      wr(6'h18, 8'h00);
      @(negedge clock);
      check(8'(pin_cmd_out), 8'h00);
      step(RFCFG_ST_SLEEP, 0);
      check(8'(xosc_enable), 8'h00);
      wr(6'h18, 8'h01);
      repeat (2) @(negedge clock);
      check(8'(xosc_enable), 8'h01);
      step(RFCFG_ST_IDLE, 0);
      $display("test pins and crystal done");
      for (int p = 0; p < 3; p++)
      begin
         wr(6'h18, 8'(p << 4));
         @(negedge clock);
         calibrate_strobe = 1;
         expq.push_back(1'b1);
         @(negedge clock);
         calibrate_strobe = 0;
         step(RFCFG_ST_TX, p == 1);
         step(RFCFG_ST_IDLE, p == 2);
         step(RFCFG_ST_TX_SYNTH_ON, p == 1);
         step(RFCFG_ST_TX, 0);
         step(RFCFG_ST_IDLE, p == 2);
         check(8'(expq.size()), 8'h00);
      end
      do_reset();
      check(8'(config_out), 8'h04);
      wr(6'h18, 8'h30);
      for (int i = 1; i <= 8; i++)
      begin
         step(RFCFG_ST_RX, 0);
         step(RFCFG_ST_IDLE, i % 4 == 0);
      end
      check(8'(expq.size()), 8'h00);
      $display("test calibration done");
      power_on(2'h0, 1);
      power_on(2'h1, 16);
      power_on(2'h2, 64);
      power_on(2'h3, 256);
      $display("test power-on done");
      tally_and_finish();
   end
endmodule : tb_rfcfg_radio_fsm_config
`default_nettype wire

//--- verilog/rfcfg_pkg.sv
// rfcfg_pkg: constants and types for the radio state machine configuration register
// assumes: one crystal-derived clock, register access from the serial host decoder
`default_nettype none
package rfcfg_pkg;

   // ==========================================================
   // register map
   localparam logic [5:0] RFCFG_ADDR_CONFIG_ZERO = 6'h18;
   localparam int         RFCFG_DATA_W           = 8;

   // field positions
   localparam int RFCFG_AUTOCAL_LSB = 4;
   localparam int RFCFG_TIMEOUT_LSB = 2;
   localparam int RFCFG_PIN_CTRL_BIT = 1;
   localparam int RFCFG_XOSC_ON_BIT  = 0;

   // reset values
   localparam logic [1:0] RFCFG_AUTOCAL_RST  = 2'h0;
   localparam logic [1:0] RFCFG_TIMEOUT_RST  = 2'h1;
   localparam logic       RFCFG_PIN_CTRL_RST = 1'b0;
   localparam logic       RFCFG_XOSC_ON_RST  = 1'b0;

   // ==========================================================
   // timing: ripple counter is six bits, expirations counted in ripple wraps of 64 crystal periods
   localparam int         RFCFG_RIPPLE_W  = 6;
   localparam int         RFCFG_EXPIRE_W  = 9;
   localparam logic [8:0] RFCFG_EXPIRE_0  = 9'h001;
   localparam logic [8:0] RFCFG_EXPIRE_1  = 9'h010;
   localparam logic [8:0] RFCFG_EXPIRE_2  = 9'h040;
   localparam logic [8:0] RFCFG_EXPIRE_3  = 9'h100;
   localparam logic [1:0] RFCFG_CAL_EVERY = 2'h3;   // fourth return: count 0..3

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      RFCFG_CAL_NEVER,
      RFCFG_CAL_FROM_IDLE,
      RFCFG_CAL_TO_IDLE,
      RFCFG_CAL_FOURTH
   } rfcfg_cal_policy_t;

   typedef enum logic [2:0] {
      RFCFG_ST_SLEEP,
      RFCFG_ST_IDLE,
      RFCFG_ST_RX,
      RFCFG_ST_TX,
      RFCFG_ST_TX_SYNTH_ON
   } rfcfg_radio_state_t;

   typedef struct packed {
      rfcfg_cal_policy_t auto_calibration_policy;
      logic [1:0]        power_on_ready_timeout;
      logic              pin_ctrl_en;
      logic              xosc_force_on;
   } rfcfg_config_t;

   typedef struct packed {
      logic go_rx;
      logic go_tx;
      logic go_idle;
   } rfcfg_pin_cmd_t;

endpackage : rfcfg_pkg
`default_nettype wire

//--- verilog/rfcfg_radio_fsm_config.sv
// rfcfg_radio_fsm_config: configuration register zero of the main radio state machine,
// with auto-calibration policy, power-on ready timeout, pin control gate and crystal hold
// assumes: clock is the crystal clock; register strobes come from the serial host decoder
`timescale 1ns/1ps
`default_nettype none
module rfcfg_radio_fsm_config
(
   // clock and reset
   input  wire logic                          clock,
   input  wire logic                          resetn,
   // register access from the host decoder
   input  wire logic [5:0]                    reg_addr,
   input  wire logic                          reg_wr,
   input  wire logic [rfcfg_pkg::RFCFG_DATA_W-1:0] reg_wdata,
   output logic [rfcfg_pkg::RFCFG_DATA_W-1:0] reg_rdata,
   // radio state and calibration
   input  wire rfcfg_pkg::rfcfg_radio_state_t radio_state,
   input  wire logic                          calibrate_strobe,
   output logic                               cal_start,
   // crystal and power-on
   input  wire logic                          xosc_stable,
   output logic                               chip_ready_n,
   output logic                               xosc_enable,
   // pin radio control
   input  wire rfcfg_pkg::rfcfg_pin_cmd_t     pin_cmd,
   output rfcfg_pkg::rfcfg_pin_cmd_t          pin_cmd_out,
   // configuration view for the main state machine
   output rfcfg_pkg::rfcfg_config_t           config_out
);
   import rfcfg_pkg::*;

   // ==========================================================
   // helpers
   // expire count selected by the timeout field
   function automatic logic [RFCFG_EXPIRE_W-1:0] expire_target(input logic [1:0] sel);
      case (sel)
         2'h0:    expire_target = RFCFG_EXPIRE_0;
         2'h1:    expire_target = RFCFG_EXPIRE_1;
         2'h2:    expire_target = RFCFG_EXPIRE_2;
         default: expire_target = RFCFG_EXPIRE_3;
      endcase
   endfunction : expire_target

   // true for receive or transmit
   function automatic logic is_rx_tx(input rfcfg_radio_state_t st);
      is_rx_tx = (st == RFCFG_ST_RX) || (st == RFCFG_ST_TX);
   endfunction : is_rx_tx

   // ==========================================================
   // configuration register
   rfcfg_config_t cfg;
   rfcfg_config_t next_cfg;
   logic          hit;

   assign hit = (reg_addr == RFCFG_ADDR_CONFIG_ZERO);

   // next register value on a host write
   always_comb
   begin
      next_cfg = cfg;
      if (reg_wr && hit)
      begin
         next_cfg.auto_calibration_policy =
            rfcfg_cal_policy_t'(reg_wdata[RFCFG_AUTOCAL_LSB +: 2]);
         next_cfg.power_on_ready_timeout = reg_wdata[RFCFG_TIMEOUT_LSB +: 2];
         next_cfg.pin_ctrl_en            = reg_wdata[RFCFG_PIN_CTRL_BIT];
         next_cfg.xosc_force_on          = reg_wdata[RFCFG_XOSC_ON_BIT];
      end
   end

   // register storage
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         cfg.auto_calibration_policy <= rfcfg_cal_policy_t'(RFCFG_AUTOCAL_RST);
         cfg.power_on_ready_timeout  <= RFCFG_TIMEOUT_RST;
         cfg.pin_ctrl_en             <= RFCFG_PIN_CTRL_RST;
         cfg.xosc_force_on           <= RFCFG_XOSC_ON_RST;
      end
      else
      begin
         cfg <= next_cfg;
      end
   end

   // read data, reserved bits read zero, unmapped addresses read zero
   logic [RFCFG_DATA_W-1:0] next_rdata;

   always_comb
   begin
      next_rdata = '0;
      if (hit)
      begin
         next_rdata[RFCFG_AUTOCAL_LSB +: 2] = cfg.auto_calibration_policy;
         next_rdata[RFCFG_TIMEOUT_LSB +: 2] = cfg.power_on_ready_timeout;
         next_rdata[RFCFG_PIN_CTRL_BIT]     = cfg.pin_ctrl_en;
         next_rdata[RFCFG_XOSC_ON_BIT]      = cfg.xosc_force_on;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!resetn)
         reg_rdata <= '0;
      else
         reg_rdata <= next_rdata;
   end

   // ==========================================================
   // automatic calibration
   rfcfg_radio_state_t prev_state;
   logic [1:0]         return_cnt;
   logic [1:0]         next_return_cnt;
   logic               next_cal_start;
   logic               leave_idle;
   logic               back_to_idle;

   // transitions seen between consecutive cycles
   assign leave_idle   = (prev_state == RFCFG_ST_IDLE) &&
                         (is_rx_tx(radio_state) || radio_state == RFCFG_ST_TX_SYNTH_ON);
   assign back_to_idle = is_rx_tx(prev_state) && (radio_state == RFCFG_ST_IDLE);

   // policy decode; manual strobe always calibrates
   always_comb
   begin
      next_cal_start  = calibrate_strobe;
      next_return_cnt = return_cnt;
      case (cfg.auto_calibration_policy)
         RFCFG_CAL_NEVER:     next_cal_start = calibrate_strobe;
         RFCFG_CAL_FROM_IDLE: if (leave_idle) next_cal_start = 1'b1;
         RFCFG_CAL_TO_IDLE:   if (back_to_idle) next_cal_start = 1'b1;
         RFCFG_CAL_FOURTH:
         begin
            if (back_to_idle)
            begin
               if (return_cnt == RFCFG_CAL_EVERY)
               begin
                  next_cal_start  = 1'b1;
                  next_return_cnt = '0;
               end
               else
                  next_return_cnt = return_cnt + 2'h1;
            end
         end
         default: next_cal_start = calibrate_strobe;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         prev_state <= RFCFG_ST_SLEEP;
         return_cnt <= '0;
         cal_start  <= 1'b0;
      end
      else
      begin
         prev_state <= radio_state;
         return_cnt <= next_return_cnt;
         cal_start  <= next_cal_start;
      end
   end

   // ==========================================================
   // power-on ready timeout, counted in crystal clock periods
   logic [RFCFG_RIPPLE_W-1:0] ripple;
   logic [RFCFG_RIPPLE_W-1:0] next_ripple;
   logic [RFCFG_EXPIRE_W-1:0] expires;
   logic [RFCFG_EXPIRE_W-1:0] next_expires;
   logic                      next_chip_ready_n;

   // ripple counter runs only while crystal stable; restarts when it drops
   always_comb
   begin
      next_ripple       = ripple;
      next_expires      = expires;
      next_chip_ready_n = chip_ready_n;
      if (!xosc_stable)
      begin
         next_ripple       = '0;
         next_expires      = '0;
         next_chip_ready_n = 1'b1;
      end
      else if (chip_ready_n)
      begin
         next_ripple = ripple + 6'h01;
         if (ripple == '1)
         begin
            next_expires = expires + 9'h001;
            if (next_expires == expire_target(cfg.power_on_ready_timeout))
               next_chip_ready_n = 1'b0;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         ripple       <= '0;
         expires      <= '0;
         chip_ready_n <= 1'b1;
      end
      else
      begin
         ripple       <= next_ripple;
         expires      <= next_expires;
         chip_ready_n <= next_chip_ready_n;
      end
   end

   // ==========================================================
   // pin control gate and crystal hold
   rfcfg_pin_cmd_t next_pin_cmd_out;
   logic           next_xosc_enable;

   always_comb
   begin
      next_pin_cmd_out = cfg.pin_ctrl_en ? pin_cmd : '0;
      next_xosc_enable = (radio_state != RFCFG_ST_SLEEP) || cfg.xosc_force_on;
   end

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         pin_cmd_out <= '0;
         xosc_enable <= 1'b1;
      end
      else
      begin
         pin_cmd_out <= next_pin_cmd_out;
         xosc_enable <= next_xosc_enable;
      end
   end

   assign config_out = cfg;

endmodule : rfcfg_radio_fsm_config
`default_nettype wire
